// [hw/encdiv_pkg.sv]
// Shared constants and types for the encoder divider and multiturn block.
// Assumes one 200 MHz drive clock; configuration is latched at power-up.
package encdiv_pkg;
	localparam int          DIV_W         = 15;
	localparam int          PHASE_W       = 16;
	localparam logic [14:0] DIV_MIN       = 15'h0010;
	localparam logic [14:0] DIV_MAX_13    = 15'h0800;
	localparam logic [14:0] DIV_CLAMP_13  = 15'h0801;
	localparam logic [14:0] DIV_MAX_16    = 15'h4000;
	localparam logic [15:0] PPR_13        = 16'h0800;
	localparam logic [15:0] PPR_16        = 16'h4000;
	localparam logic [15:0] LIMIT_DEFAULT = 16'hFFFF;
	localparam logic [15:0] LIMIT_MAX_USR = 16'hFFFE;
	localparam logic [15:0] MT_SIGNED_MAX = 16'h7FFF;
	localparam logic [15:0] MT_SIGNED_MIN = 16'h8000;
	localparam logic [15:0] MT_ZERO       = 16'h0000;
	localparam logic [14:0] DIV_RESET     = 15'h4000;
	localparam logic        USAGE_ABS     = 1'b0;
	localparam logic        USAGE_INC     = 1'b1;
	// Alarm code bits are active low: 0 means ON
	localparam logic [2:0]  ALARM_NONE    = 3'b111;
	localparam logic [2:0]  ALARM_LIMIT   = 3'b010;

	typedef enum logic [1:0] {
		ST_BOOT  = 2'b00,
		ST_CHECK = 2'b01,
		ST_RUN   = 2'b10
	} boot_state_t;
endpackage : encdiv_pkg

// [hw/quad_if.sv]
// Carries the quadrature phase step between the core and the pulse former.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface quad_if;
	logic step;
	logic dir_rev;
	logic index;
	modport core (output step, output dir_rev, output index);
	modport former (input step, input dir_rev, input index);
endinterface : quad_if

// [hw/quad_former.sv]
// Turns divided steps into A/B quadrature and C index, with complements.
// Assumes one step per clock at most; outputs are registered.
`timescale 1ns/1ps
module quad_former
	import encdiv_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_sync_n,
	// Step stream
	quad_if.former    q,
	// Line pairs
	output logic      quad_out_a,
	output logic      quad_out_a_n,
	output logic      quad_out_b,
	output logic      quad_out_b_n,
	output logic      index_out_c,
	output logic      index_out_c_n
);
	typedef struct packed {
		logic [1:0] gray;
		logic       c;
	} former_t;

	former_t cur, next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.c = q.index;
		if (q.step) begin
			// {A,B} runs 00,10,11,01 forward: A leads, B lags; reverse runs back
			if (!q.dir_rev) begin
				next_cur.gray = {~cur.gray[0], cur.gray[1]};
			end else begin
				next_cur.gray = {cur.gray[0], ~cur.gray[1]};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign quad_out_a    = cur.gray[1];
	assign quad_out_a_n  = ~cur.gray[1];
	assign quad_out_b    = cur.gray[0];
	assign quad_out_b_n  = ~cur.gray[0];
	assign index_out_c   = cur.c;
	assign index_out_c_n = ~cur.c;
endmodule : quad_former

// [hw/encoder_divider_multiturn.sv]
// Divided encoder output and absolute multiturn counter of a servo drive.
// Assumes motor encoder counts arrive as one-cycle step pulses on sys_clk.
// How it works
// - Drive A, B and C output phases, each with a complemented pair.
// - Output pulses per revolution come from the latched divider setting.
// - Divider range is 16..2048 for 13-bit, 16..16384 for 16-bit.
// - A and B both run at divided rate, four edges per pulse.
// - A 13-bit encoder clamps output to 2048 when divider exceeds 2048.
// - Divider changes act only after the next power cycle.
// - Usage 0 keeps absolute multiturn count; usage 1 runs incremental.
// - Usage and limit changes act only after power off and on.
// - Default limit 65535 keeps signed count from -32768 to 32767.
// - Default mode wraps +32767 up to -32768 and back down.
// - Other limits keep an unsigned count from 0 up to the limit.
// - User mode wraps 0 down to limit and limit up to 0.
// - Encoder stored limit resets to 65535, matching drive default.
// - Power-up limit mismatch in usage 0 raises alarm, bits 1 and 3 low.
// - Encoder limit rewrite accepted only while disagreement alarm stands.
// - Encoder setup runs only with servo off, refused when on.
`timescale 1ns/1ps
module encoder_divider_multiturn
	import encdiv_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Motor encoder counts
	input  wire logic        enc_step,
	input  wire logic        enc_dir_rev,
	input  wire logic        enc_is_16bit,
	// Configuration, sampled once after reset
	input  wire logic [14:0] pulse_divider_setting,
	input  wire logic        encoder_usage_select,
	input  wire logic [15:0] multiturn_limit_setting,
	// Commands
	input  wire logic        servo_on,
	input  wire logic        encoder_setup_command,
	input  wire logic        encoder_limit_write_command,
	// Encoder output lines
	output logic             quad_out_a,
	output logic             quad_out_a_n,
	output logic             quad_out_b,
	output logic             quad_out_b_n,
	output logic             index_out_c,
	output logic             index_out_c_n,
	// Status
	output logic [15:0]      multiturn_count,
	output logic [15:0]      single_turn_pos,
	output logic             absolute_mode,
	output logic             limit_alarm,
	output logic             alarm_code_bit1,
	output logic             alarm_code_bit2,
	output logic             alarm_code_bit3,
	output logic             setup_done,
	output logic             setup_refused,
	output logic             limit_write_done,
	output logic             limit_write_refused,
	output logic [15:0]      encoder_stored_limit,
	output logic [14:0]      active_divider
);
	typedef struct packed {
		boot_state_t state;
		logic [14:0] div;
		logic [15:0] ppr;
		logic        usage;
		logic [15:0] limit;
		logic [15:0] enc_limit;
		logic [15:0] pos;
		logic [15:0] acc;
		logic [7:0]  owe;
		logic [15:0] mt;
		logic        alarm;
		logic        step;
		logic        dir;
		logic        idx;
		logic        setup_ok;
		logic        setup_no;
		logic        lw_ok;
		logic        lw_no;
	} core_t;

	core_t cur, next_cur;
	logic  rst_meta, rst_sync_n;
	// Signed edge count from one encoder count, and the new remainder
	logic [3:0]  owed;
	logic [15:0] rem;

	// Two-stage release keeps the async reset clean on deassertion
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Limit the divider to what the encoder allows
	function automatic logic [14:0] clamp_div(input logic [14:0] d, input logic is16);
		logic [14:0] r;
		r = d;
		if (d < DIV_MIN) begin
			r = DIV_MIN;
		end else if (is16 && d > DIV_MAX_16) begin
			r = DIV_MAX_16;
		end else if (!is16 && d >= DIV_CLAMP_13) begin
			r = DIV_MAX_13;
		end
		return r;
	endfunction : clamp_div

	// Next multiturn value for one turn in either direction
	function automatic logic [15:0] turn_step(input logic [15:0] v, input logic rev,
		input logic [15:0] lim);
		logic [15:0] r;
		r = v;
		if (lim == LIMIT_DEFAULT) begin
			// Plain 16-bit wrap gives the signed behaviour directly
			if (!rev) begin
				r = (v == MT_SIGNED_MAX) ? MT_SIGNED_MIN : v + 16'h0001;
			end else begin
				r = (v == MT_SIGNED_MIN) ? MT_SIGNED_MAX : v - 16'h0001;
			end
		end else begin
			if (!rev) begin
				r = (v >= lim) ? MT_ZERO : v + 16'h0001;
			end else begin
				r = (v == MT_ZERO) ? lim : v - 16'h0001;
			end
		end
		return r;
	endfunction : turn_step

	// Scaled divider: each count moves 4*div over ppr quadrature edges, so a
	// full turn gives div pulses on both A and B. Forward carries and reverse
	// borrows, so swinging back and forth never gains or loses edges.
	function automatic logic [19:0] rate_step(input logic [15:0] a, input logic [14:0] d,
		input logic [15:0] p, input logic rev);
		logic [17:0] s;
		logic [3:0]  n;
		n = 4'h0;
		if (!rev) begin
			s = {2'b00, a} + {1'b0, d, 2'b00};
			for (int k = 0; k < 4; k++) begin
				if (s >= {2'b00, p}) begin
					s = s - {2'b00, p};
					n = n + 4'h1;
				end
			end
		end else begin
			s = {2'b00, a} - {1'b0, d, 2'b00};
			for (int k = 0; k < 4; k++) begin
				if (s[17]) begin
					s = s + {2'b00, p};
					n = n - 4'h1;
				end
			end
		end
		return {n, s[15:0]};
	endfunction : rate_step

	always_comb begin
		next_cur          = cur;
		next_cur.step     = 1'b0;
		next_cur.idx      = 1'b0;
		next_cur.setup_ok = 1'b0;
		next_cur.setup_no = 1'b0;
		next_cur.lw_ok    = 1'b0;
		next_cur.lw_no    = 1'b0;
		{owed, rem}       = rate_step(cur.acc, cur.div, cur.ppr, enc_dir_rev);
		case (cur.state)
			ST_BOOT: begin
				// Settings are taken only here, so changes wait for a power cycle
				next_cur.div   = clamp_div(pulse_divider_setting, enc_is_16bit);
				next_cur.ppr   = enc_is_16bit ? PPR_16 : PPR_13;
				next_cur.usage = encoder_usage_select;
				next_cur.limit = multiturn_limit_setting;
				next_cur.state = ST_CHECK;
			end
			ST_CHECK: begin
				next_cur.alarm = (cur.usage == USAGE_ABS) && (cur.limit != cur.enc_limit);
				next_cur.state = ST_RUN;
			end
			ST_RUN: begin
				// One owed edge per clock, so A and B never move in the same cycle
				if (cur.owe != 8'h00) begin
					next_cur.step = 1'b1;
					next_cur.dir  = cur.owe[7];
					next_cur.owe  = cur.owe[7] ? cur.owe + 8'h01 : cur.owe - 8'h01;
				end
				if (enc_step) begin
					// Up to four edges per count at the top divider; the backlog
					// absorbs them, but counts faster than one per four clocks overrun it
					next_cur.acc = rem;
					next_cur.owe = next_cur.owe + {{4{owed[3]}}, owed};
					if (!enc_dir_rev) begin
						if (cur.pos == cur.ppr - 16'h0001) begin
							next_cur.pos = MT_ZERO;
							next_cur.idx = 1'b1;
							if (cur.usage == USAGE_ABS) begin
								next_cur.mt = turn_step(cur.mt, 1'b0, cur.limit);
							end
						end else begin
							next_cur.pos = cur.pos + 16'h0001;
						end
					end else begin
						if (cur.pos == MT_ZERO) begin
							next_cur.pos = cur.ppr - 16'h0001;
							next_cur.idx = 1'b1;
							if (cur.usage == USAGE_ABS) begin
								next_cur.mt = turn_step(cur.mt, 1'b1, cur.limit);
							end
						end else begin
							next_cur.pos = cur.pos - 16'h0001;
						end
					end
				end
				if (encoder_setup_command) begin
					if (servo_on) begin
						next_cur.setup_no = 1'b1;
					end else begin
						next_cur.setup_ok = 1'b1;
						next_cur.mt       = MT_ZERO;
						next_cur.pos      = MT_ZERO;
						next_cur.acc      = MT_ZERO;
					end
				end
				if (encoder_limit_write_command) begin
					if (cur.alarm) begin
						// Alarm stays until the next power cycle re-checks
						next_cur.enc_limit = cur.limit;
						next_cur.lw_ok     = 1'b1;
					end else begin
						next_cur.lw_no = 1'b1;
					end
				end
			end
			default: begin
				next_cur.state = ST_BOOT;
			end
		endcase
	end

	// Stored encoder limit survives soft reset only through the reset value
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cur           <= '0;
			cur.state     <= ST_BOOT;
			cur.div       <= DIV_RESET;
			cur.ppr       <= PPR_16;
			cur.usage     <= USAGE_ABS;
			cur.limit     <= LIMIT_DEFAULT;
			cur.enc_limit <= LIMIT_DEFAULT;
		end else begin
			cur <= next_cur;
		end
	end

	quad_if q ();
	assign q.step    = cur.step;
	assign q.dir_rev = cur.dir;
	assign q.index   = cur.idx;

	quad_former u_former (
		.sys_clk       (sys_clk),
		.rst_sync_n    (rst_sync_n),
		.q             (q),
		.quad_out_a    (quad_out_a),
		.quad_out_a_n  (quad_out_a_n),
		.quad_out_b    (quad_out_b),
		.quad_out_b_n  (quad_out_b_n),
		.index_out_c   (index_out_c),
		.index_out_c_n (index_out_c_n)
	);

	assign multiturn_count      = cur.mt;
	assign single_turn_pos      = cur.pos;
	assign absolute_mode        = (cur.usage == USAGE_ABS);
	assign limit_alarm          = cur.alarm;
	assign alarm_code_bit1      = cur.alarm ? ALARM_LIMIT[0] : ALARM_NONE[0];
	assign alarm_code_bit2      = cur.alarm ? ALARM_LIMIT[1] : ALARM_NONE[1];
	assign alarm_code_bit3      = cur.alarm ? ALARM_LIMIT[2] : ALARM_NONE[2];
	assign setup_done           = cur.setup_ok;
	assign setup_refused        = cur.setup_no;
	assign limit_write_done     = cur.lw_ok;
	assign limit_write_refused  = cur.lw_no;
	assign encoder_stored_limit = cur.enc_limit;
	assign active_divider       = cur.div;
endmodule : encoder_divider_multiturn

// [verif/encdiv_monitor.sv]
// Port checker for the encoder divider block.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module encdiv_monitor
	import encdiv_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// Watched ports
	input wire logic        quad_out_a,
	input wire logic        quad_out_a_n,
	input wire logic        quad_out_b,
	input wire logic        quad_out_b_n,
	input wire logic        servo_on,
	input wire logic        encoder_setup_command,
	input wire logic        encoder_limit_write_command,
	input wire logic        limit_alarm,
	input wire logic        alarm_code_bit1,
	input wire logic        alarm_code_bit2,
	input wire logic        alarm_code_bit3,
	input wire logic        setup_done,
	input wire logic        setup_refused,
	input wire logic        limit_write_refused,
	input wire logic [15:0] multiturn_count,
	input wire logic [14:0] active_divider
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Boot takes a few edges; commands only count once running
	logic [2:0] up;
	wire        rdy = (up == 3'h7);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			up <= 3'h0;
		else if (!rdy)
			up <= up + 3'h1;
	end
	property p_pair; quad_out_a_n == !quad_out_a && quad_out_b_n == !quad_out_b; endproperty
	a_pair: assert property (p_pair) else $error("pair");
	property p_gray; $changed(quad_out_a) |-> $stable(quad_out_b); endproperty
	a_gray: assert property (p_gray) else $error("gray");
	property p_alm; limit_alarm |-> {alarm_code_bit1, alarm_code_bit2, alarm_code_bit3} == ALARM_LIMIT; endproperty
	a_alm: assert property (p_alm) else $error("alarm code");
	property p_noalm; !limit_alarm |-> {alarm_code_bit1, alarm_code_bit2, alarm_code_bit3} == ALARM_NONE; endproperty
	a_noalm: assert property (p_noalm) else $error("idle code");
	property p_wref; rdy && encoder_limit_write_command && !limit_alarm |=> limit_write_refused; endproperty
	a_wref: assert property (p_wref) else $error("write");
	property p_sref; rdy && encoder_setup_command && servo_on |=> setup_refused && !setup_done; endproperty
	a_sref: assert property (p_sref) else $error("setup on");
	property p_sdone; rdy && encoder_setup_command && !servo_on |=> setup_done && multiturn_count == MT_ZERO; endproperty
	a_sdone: assert property (p_sdone) else $error("setup off");
	property p_div; rdy |=> $stable(active_divider); endproperty
	a_div: assert property (p_div) else $error("divider");
endmodule : encdiv_monitor
bind encoder_divider_multiturn encdiv_monitor i_encdiv_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
	.quad_out_a(quad_out_a), .quad_out_a_n(quad_out_a_n), .quad_out_b(quad_out_b),
	.quad_out_b_n(quad_out_b_n), .servo_on(servo_on), .encoder_setup_command(encoder_setup_command),
	.encoder_limit_write_command(encoder_limit_write_command), .limit_alarm(limit_alarm),
	.alarm_code_bit1(alarm_code_bit1), .alarm_code_bit2(alarm_code_bit2),
	.alarm_code_bit3(alarm_code_bit3), .setup_done(setup_done), .setup_refused(setup_refused),
	.limit_write_refused(limit_write_refused), .multiturn_count(multiturn_count),
	.active_divider(active_divider));

// [verif/quad_host_model.sv]
// Host side: counts quadrature edges and index pulses.
// Assumes sys_clk samples faster than any line edge.
`timescale 1ns/1ps
module quad_host_model (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic a,
	input  wire logic a_n,
	input  wire logic b,
	input  wire logic b_n,
	input  wire logic c,
	output int        edges,
	output int        turns,
	output int        faults
);
	logic pa;
	logic pb;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pa <= 1'b0;
			pb <= 1'b0;
			edges <= 0;
			turns <= 0;
			faults <= 0;
		end else begin
			pa <= a;
			pb <= b;
			if (a_n === a || b_n === b || (a !== pa && b !== pb))
				faults <= faults + 1;
			else if (a !== pa || b !== pb)
				edges <= edges + ((a === !pb) ? 1 : -1);
			if (c === 1'b1)
				turns <= turns + 1;
		end
	end
endmodule : quad_host_model

// [verif/encoder_divider_multiturn_tb_top.sv]
// Bench for the encoder divider block with a counting host.
// Assumes config is latched by a fresh reset in each test.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module encoder_divider_multiturn_tb_top;
	import encdiv_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        stp = 1'b0;
	logic        rev = 1'b0;
	logic        e16 = 1'b0;
	logic [14:0] div = DIV_MIN;
	logic        use_inc = USAGE_ABS;
	logic [15:0] lim = LIMIT_DEFAULT;
	logic        son = 1'b0;
	logic        scmd = 1'b0;
	logic        wcmd = 1'b0;
	logic        qa, qan, qb, qbn, qc, qcn, absm, alm, b1, b2, b3, sd, sr, wd, wr;
	logic [15:0] mt, stl, pos;
	logic [14:0] adiv;
	int          edges, turns, faults, bad_count, checked;
	always #2.5 sys_clk = ~sys_clk;
	encoder_divider_multiturn i_encoder_divider_multiturn (.sys_clk(sys_clk), .rst_n(rst_n),
		.enc_step(stp), .enc_dir_rev(rev), .enc_is_16bit(e16), .pulse_divider_setting(div),
		.encoder_usage_select(use_inc), .multiturn_limit_setting(lim), .servo_on(son),
		.encoder_setup_command(scmd), .encoder_limit_write_command(wcmd), .quad_out_a(qa),
		.quad_out_a_n(qan), .quad_out_b(qb), .quad_out_b_n(qbn), .index_out_c(qc),
		.index_out_c_n(qcn), .multiturn_count(mt), .single_turn_pos(pos), .absolute_mode(absm),
		.limit_alarm(alm), .alarm_code_bit1(b1), .alarm_code_bit2(b2), .alarm_code_bit3(b3),
		.setup_done(sd), .setup_refused(sr), .limit_write_done(wd), .limit_write_refused(wr),
		.encoder_stored_limit(stl), .active_divider(adiv));
	quad_host_model i_quad_host_model (.sys_clk(sys_clk), .rst_n(rst_n), .a(qa), .a_n(qan),
		.b(qb), .b_n(qbn), .c(qc), .edges(edges), .turns(turns), .faults(faults));
	task automatic boot(input logic w, input logic [14:0] d, input logic u, input logic [15:0] l);
		@(posedge sys_clk) #1;
		rst_n = 1'b0;
		{e16, div, use_inc, lim} = {w, d, u, l};
		repeat (2) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
	endtask : boot
	task automatic steps(input int n, input logic r);
		rev = r;
		stp = 1'b1;
		repeat (n) @(posedge sys_clk);
		#1 stp = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : steps
	// One request cycle; answer is read right after its edge
	task automatic pulse(input logic s);
		@(posedge sys_clk) #1;
		{scmd, wcmd} = {s, !s};
		@(posedge sys_clk) #1;
		{scmd, wcmd} = 2'b00;
	endtask : pulse
	task automatic close_out;
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	logic [14:0] td[4] = '{15'h0bb8, 15'h0801, DIV_MIN, DIV_MAX_16};
	logic [14:0] te[4] = '{DIV_MAX_13, DIV_MAX_13, DIV_MIN, DIV_MAX_16};
	initial begin
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 4; i++) begin
			boot(i > 1, td[i], USAGE_ABS, LIMIT_DEFAULT);
			`CHK("divider", te[i], adiv)
		end
		div = DIV_MIN;
		repeat (3) @(posedge sys_clk);
		`CHK("divider held", DIV_MAX_16, adiv)
		boot(1'b0, DIV_MIN, USAGE_ABS, LIMIT_DEFAULT);
		`CHK("code", {ALARM_NONE, LIMIT_DEFAULT}, {b1, b2, b3, stl})
		`CHK("index pair", 2'b01, {qc, qcn})
		pulse(1'b0);
		`CHK("write refused", 2'b01, {wd, wr})
		son = 1'b1;
		pulse(1'b1);
		`CHK("setup refused", 2'b01, {sd, sr})
		son = 1'b0;
		pulse(1'b1);
		`CHK("setup done", 2'b10, {sd, sr})
		steps(2048, 1'b0);
		`CHK("edges", 64, edges)
		`CHK("turn", {16'h0001, 32'h1}, {mt, turns})
		`CHK("pos fwd", MT_ZERO, pos)
		steps(2049, 1'b1);
		`CHK("signed", 16'hffff, mt)
		`CHK("pos back", PPR_13 - 16'h0001, pos)
		`CHK("edges back", -1, edges)
		`CHK("faults", 0, faults)
		boot(1'b0, DIV_MIN, USAGE_ABS, 16'h0003);
		`CHK("alarm", {1'b1, ALARM_LIMIT}, {alm, b1, b2, b3})
		pulse(1'b0);
		`CHK("write", {2'b10, 16'h0003}, {wd, wr, stl})
		{lim, use_inc} = {LIMIT_DEFAULT, USAGE_INC};
		steps(1, 1'b1);
		`CHK("wrap down", {1'b1, 16'h0003}, {absm, mt})
		steps(1, 1'b0);
		`CHK("wrap up", MT_ZERO, mt)
		boot(1'b0, DIV_MIN, USAGE_INC, LIMIT_DEFAULT);
		steps(2048, 1'b0);
		`CHK("incremental", {1'b0, MT_ZERO}, {absm, mt})
		close_out();
	end
	// Tests need about 6300 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		close_out();
	end
endmodule : encoder_divider_multiturn_tb_top
